/* File: dmc_mode_regs.sv */
/*
 Mode-control register bank with its serial port slave.
 Assumes the serial clock, select and data pins are asynchronous to
 i_core_clk and at least four times slower; one byte per frame after an
 instruction byte (bit 7 read, bits 4:0 address). Pin levels are worked
 out from the enables outside.
*/
`timescale 1ns/100ps
// Notes on behaviour
// - Registers 0x00-0x0d reached only through serial port
// - Reset defaults: input-only, MSB first, loop off
// - Address 0x00 bit 2 selects shared resistor
// - Address 0x02 bit 2 inverts single port clock
// - Address 0x02 bit 1 inverts channel select
// - Offset direction bit 7 picks complement output
// - Soft reset bit resets others to defaults, 0x00 takes rest of byte
// - Address 0x01 bits 7:6 pick interpolation
// - Address 0x01 bits 5:4 pick modulation
// - Offset magnitude is ten bits, high byte first
module dmc_mode_regs #(
   parameter logic [7:0] VERSION_ID = 8'h0a // Arbitrary value
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_spi_clk,
   input wire logic i_spi_cs_n,
   input wire logic i_sdio,
   output logic o_sdio,
   output logic o_sdio_oe_n,
   output logic o_sdo,
   output logic o_sdo_oe_n,
   input wire logic i_loop_locked,
   input wire logic i_single_port_clock_raw,
   input wire logic i_channel_select,
   output logic o_single_port_clock,
   output logic o_channel_select_eff,
   output logic o_restart,
   output logic o_sdio_bidir,
   output logic o_lsb_first,
   output logic o_sleep,
   output logic o_power_down,
   output logic o_single_resistor,
   output logic [1:0] o_interp_sel,
   output logic [1:0] o_mod_sel,
   output logic o_zero_stuff,
   output logic o_real_mix,
   output logic o_mod_positive,
   output logic o_pin8_is_clock,
   output logic o_unsigned_data,
   output logic o_one_port,
   output logic o_clk_strong,
   output logic o_data_clk_invert,
   output logic o_q_first,
   output logic o_clk_on_sdo,
   output logic [1:0] o_prescale_sel,
   output logic o_loop_enable,
   output logic o_pump_manual,
   output logic [2:0] o_pump_current,
   output logic [dmc_pkg::DMC_DW-1:0] o_i_fine_gain,
   output logic [3:0] o_i_coarse_gain,
   output logic [9:0] o_i_offset_mag,
   output logic o_i_offset_to_comp,
   output logic [dmc_pkg::DMC_DW-1:0] o_q_fine_gain,
   output logic [3:0] o_q_coarse_gain,
   output logic [9:0] o_q_offset_mag,
   output logic o_q_offset_to_comp
);
   import dmc_pkg::*;

   logic [7:0] regs_r [0:DMC_NREG-1];
   logic [2:0] sclk_s_r, csn_s_r;
   logic [1:0] sdi_s_r, lock_s_r, spc_s_r, sel_s_r;
   logic [4:0] cnt_r;
   logic [7:0] sh_r, instr_r, out_r, wr_data_r;
   logic out_bit_r, wr_stb_r, restart_r, spc_r, sel_r;
   logic [4:0] wr_addr_r;

   // Third stage only feeds edge detection, never the first stage
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         sclk_s_r <= 3'h0;
         csn_s_r <= 3'h7;
         sdi_s_r <= 2'h0;
         lock_s_r <= 2'h0;
         spc_s_r <= 2'h0;
         sel_s_r <= 2'h0;
      end else begin
         sclk_s_r <= {sclk_s_r[1:0], i_spi_clk};
         csn_s_r <= {csn_s_r[1:0], i_spi_cs_n};
         sdi_s_r <= {sdi_s_r[0], i_sdio};
         lock_s_r <= {lock_s_r[0], i_loop_locked};
         spc_s_r <= {spc_s_r[0], i_single_port_clock_raw};
         sel_s_r <= {sel_s_r[0], i_channel_select};
      end
   end

   wire sel_n = csn_s_r[1];
   wire sclk_rise = sclk_s_r[1] & ~sclk_s_r[2] & ~sel_n;
   wire sclk_fall = ~sclk_s_r[1] & sclk_s_r[2] & ~sel_n;
   wire lsb_first = regs_r[0][DMC_B_LSB_FIRST];
   wire [7:0] sh_nxt = lsb_first ? {sdi_s_r[1], sh_r[7:1]} : {sh_r[6:0], sdi_s_r[1]};
   wire is_read = instr_r[DMC_B_READ];
   wire in_data = (cnt_r > DMC_CNT_INSTR_LAST);
   wire instr_done = sclk_rise & (cnt_r == DMC_CNT_INSTR_LAST);
   wire data_done = sclk_rise & (cnt_r == DMC_CNT_DATA_LAST);
   wire [4:0] rd_addr = sh_nxt[4:0];
   wire rd_mapped = (rd_addr <= DMC_A_VERSION);

   // Read view: lock status only means something with the loop on
   wire lock_view = lock_s_r[1] & regs_r[4][7];
   wire [7:0] reg0_view = {regs_r[0][7:2], lock_view, 1'b0};
   wire [7:0] rd_data = !rd_mapped ? 8'h00 :
                        (rd_addr == DMC_A_SERIAL) ? reg0_view :
                        (rd_addr == DMC_A_VERSION) ? VERSION_ID :
                        regs_r[rd_addr[3:0]];
   wire soft_rst = wr_stb_r & (wr_addr_r == DMC_A_SERIAL) & wr_data_r[DMC_B_SOFT_RST];

   always_ff @(posedge i_core_clk) begin
      if (i_rst || sel_n) begin
         cnt_r <= DMC_CNT_ZERO;
         sh_r <= 8'h00;
      end else if (sclk_rise) begin
         cnt_r <= cnt_r + 5'd1;
         sh_r <= sh_nxt;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         instr_r <= 8'h00;
         out_r <= 8'h00;
         out_bit_r <= 1'b0;
      end else if (instr_done) begin
         instr_r <= sh_nxt;
         out_r <= rd_data;
      end else if (sclk_fall && in_data) begin
         out_bit_r <= lsb_first ? out_r[0] : out_r[7];
         out_r <= lsb_first ? {1'b0, out_r[7:1]} : {out_r[6:0], 1'b0};
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         wr_stb_r <= 1'b0;
         wr_addr_r <= 5'h00;
         wr_data_r <= 8'h00;
      end else begin
         wr_stb_r <= data_done & ~is_read;
         wr_addr_r <= instr_r[4:0];
         wr_data_r <= sh_nxt;
      end
   end

   // Soft reset spares address 0x00, which takes the rest of the written byte; the bit itself is never stored
   genvar g;
   generate
      for (g = 0; g < DMC_NREG; g++) begin : g_reg
         always_ff @(posedge i_core_clk) begin
            if (i_rst)
               regs_r[g] <= DMC_RST_VAL[g];
            else if (soft_rst && g != 0)
               regs_r[g] <= DMC_RST_VAL[g];
            else if (wr_stb_r && wr_addr_r == 5'(g))
               regs_r[g] <= wr_data_r & DMC_WR_MASK[g];
         end
      end
   endgenerate

   // Pin inversions are registered once more so outputs stay glitch free
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         restart_r <= 1'b0;
         spc_r <= 1'b0;
         sel_r <= 1'b0;
      end else begin
         restart_r <= soft_rst;
         spc_r <= spc_s_r[1] ^ regs_r[2][DMC_B_SPCLK_INV];
         sel_r <= sel_s_r[1] ^ regs_r[2][DMC_B_SEL_INV];
      end
   end

   wire drive_rd = ~sel_n & is_read & in_data;
   wire bidir = regs_r[0][DMC_B_BIDIR];
   assign o_sdio = out_bit_r;
   assign o_sdio_oe_n = ~(drive_rd & bidir);
   assign o_sdo = out_bit_r;
   assign o_sdo_oe_n = ~(drive_rd & ~bidir);
   assign o_single_port_clock = spc_r;
   assign o_channel_select_eff = sel_r;
   assign o_restart = restart_r;
   assign o_sdio_bidir = bidir;
   assign o_lsb_first = lsb_first;
   assign o_sleep = regs_r[0][DMC_B_SLEEP];
   assign o_power_down = regs_r[0][DMC_B_PWR_DOWN];
   assign o_single_resistor = regs_r[0][DMC_B_ONE_RES];
   assign o_interp_sel = regs_r[1][7:6];
   assign o_mod_sel = regs_r[1][5:4];
   assign o_zero_stuff = regs_r[1][3];
   assign o_real_mix = regs_r[1][2];
   assign o_mod_positive = regs_r[1][1];
   assign o_pin8_is_clock = regs_r[1][0];
   assign o_unsigned_data = regs_r[2][7];
   assign o_one_port = regs_r[2][6];
   assign o_clk_strong = regs_r[2][5];
   assign o_data_clk_invert = regs_r[2][4];
   assign o_q_first = regs_r[2][0];
   assign o_clk_on_sdo = regs_r[3][7];
   assign o_prescale_sel = regs_r[3][1:0];
   assign o_loop_enable = regs_r[4][7];
   assign o_pump_manual = regs_r[4][6];
   assign o_pump_current = regs_r[4][2:0];
   assign o_i_fine_gain = regs_r[5];
   assign o_i_coarse_gain = regs_r[6][3:0];
   assign o_i_offset_mag = {regs_r[7], regs_r[8][1:0]};
   assign o_i_offset_to_comp = regs_r[8][DMC_B_OFS_DIR];
   assign o_q_fine_gain = regs_r[9];
   assign o_q_coarse_gain = regs_r[10][3:0];
   assign o_q_offset_mag = {regs_r[11], regs_r[12][1:0]};
   assign o_q_offset_to_comp = regs_r[12][DMC_B_OFS_DIR];

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   a_unmapped_read_zero: assert property (instr_done && !rd_mapped |=> out_r == 8'h00)
      else $error("unmapped read not zero");
   a_reset_defaults: assert property (@(posedge i_core_clk) disable iff (1'b0)
      i_rst |=> regs_r[0] == 8'h00 && regs_r[1] == 8'h04 && !o_loop_enable && o_sdo_oe_n)
      else $error("reset defaults wrong");
   a_resistor_mode: assert property (wr_stb_r && wr_addr_r == DMC_A_SERIAL
      |=> o_single_resistor == $past(wr_data_r[DMC_B_ONE_RES]))
      else $error("resistor mode not written");
   a_spclk_invert: assert property (##1 o_single_port_clock ==
      ($past(spc_s_r[1]) ^ $past(regs_r[2][DMC_B_SPCLK_INV])))
      else $error("single port clock polarity wrong");
   a_select_invert: assert property (##1 o_channel_select_eff ==
      ($past(sel_s_r[1]) ^ $past(regs_r[2][DMC_B_SEL_INV])))
      else $error("channel select polarity wrong");
   a_offset_dir: assert property (wr_stb_r && wr_addr_r == DMC_A_Q_OFS_LO && !soft_rst
      |=> o_q_offset_to_comp == $past(wr_data_r[7])
      && o_q_offset_mag[1:0] == $past(wr_data_r[1:0]))
      else $error("offset direction wrong");
   a_reserved_zero: assert property (regs_r[6][7:4] == 4'h0 && regs_r[8][6:2] == 5'h00
      && regs_r[0][DMC_B_SOFT_RST] == 1'b0)
      else $error("reserved bits not zero");
   a_soft_reset: assert property (soft_rst |=> regs_r[1] == 8'h04 && regs_r[7] == 8'h00
      && regs_r[0] == ($past(wr_data_r) & 8'hdc) && o_restart)
      else $error("soft reset wrong");
   a_interp_mod: assert property (wr_stb_r && wr_addr_r == DMC_A_FILTER
      |=> o_interp_sel == $past(wr_data_r[7:6]) && o_mod_sel == $past(wr_data_r[5:4]))
      else $error("filter fields wrong");
   a_write_latency: assert property (data_done && !is_read |=> wr_stb_r ##1 !wr_stb_r)
      else $error("write strobe timing wrong");
   c_write: cover property (wr_stb_r && wr_addr_r == DMC_A_FILTER);
   c_read: cover property (instr_done && sh_nxt[7] ##[1:200] sclk_fall && in_data);
   c_soft_rst: cover property (soft_rst);
endmodule // dmc_mode_regs

/* File: dmc_pkg.sv */
/*
 Constants for the converter mode-control register bank: register indices,
 reset values, writable-bit masks and field positions.
 Assumes byte-wide registers reached only through the serial port.
*/
package dmc_pkg;
   localparam int DMC_DW = 8;
   localparam int DMC_AW = 5;
   localparam int DMC_NREG = 14;

   localparam logic [4:0] DMC_A_SERIAL = 5'h00;
   localparam logic [4:0] DMC_A_FILTER = 5'h01;
   localparam logic [4:0] DMC_A_FORMAT = 5'h02;
   localparam logic [4:0] DMC_A_CLKOUT = 5'h03;
   localparam logic [4:0] DMC_A_LOOP = 5'h04;
   localparam logic [4:0] DMC_A_I_FINE = 5'h05;
   localparam logic [4:0] DMC_A_I_COARSE = 5'h06;
   localparam logic [4:0] DMC_A_I_OFS_HI = 5'h07;
   localparam logic [4:0] DMC_A_I_OFS_LO = 5'h08;
   localparam logic [4:0] DMC_A_Q_FINE = 5'h09;
   localparam logic [4:0] DMC_A_Q_COARSE = 5'h0a;
   localparam logic [4:0] DMC_A_Q_OFS_HI = 5'h0b;
   localparam logic [4:0] DMC_A_Q_OFS_LO = 5'h0c;
   localparam logic [4:0] DMC_A_VERSION = 5'h0d;

   // Real mix mode is the only bit that comes up set
   localparam logic [7:0] DMC_RST_VAL [0:13] = '{
      8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   // Bits that hold host data; all others ignore writes and read zero, except 0x00 bit 1 (lock status) and 0x0d (version)
   localparam logic [7:0] DMC_WR_MASK [0:13] = '{
      8'hdc, 8'hff, 8'hf7, 8'h83, 8'hc7, 8'hff, 8'h0f,
      8'hff, 8'h83, 8'hff, 8'h0f, 8'hff, 8'h83, 8'h00};

   localparam int DMC_B_BIDIR = 7;
   localparam int DMC_B_LSB_FIRST = 6;
   localparam int DMC_B_SOFT_RST = 5;
   localparam int DMC_B_SLEEP = 4;
   localparam int DMC_B_PWR_DOWN = 3;
   localparam int DMC_B_ONE_RES = 2;
   localparam int DMC_B_LOCK = 1;
   localparam int DMC_B_SPCLK_INV = 2;
   localparam int DMC_B_SEL_INV = 1;
   localparam int DMC_B_OFS_DIR = 7;
   localparam int DMC_B_READ = 7;

   localparam logic [4:0] DMC_CNT_INSTR_LAST = 5'd7;
   localparam logic [4:0] DMC_CNT_DATA_LAST = 5'd15;
   localparam logic [4:0] DMC_CNT_ZERO = 5'd0;
endpackage

/* File: dmc_spi_host.sv */
/*
 Serial host model that runs one frame at a time into the mode register bank.
 Assumes the bench resolves the shared data pin and leaves time between frames.
*/
`timescale 1ns/100ps
module dmc_spi_host (
   input wire logic i_core_clk,
   input wire logic i_miso,
   output logic o_spi_clk,
   output logic o_spi_cs_n,
   output logic o_mosi
);
   logic lsb_first;
   initial begin
      lsb_first = 1'b0;
      o_spi_clk = 1'b0;
      o_spi_cs_n = 1'b1;
      o_mosi = 1'b0;
   end
   // Clock rests low outside frames; 8 core cycles per bit
   task automatic xfer(input logic [7:0] ins, input logic [7:0] wd, output logic [7:0] rd);
      int k;
      int idx;
      logic [15:0] sh;
      sh = {ins, wd};
      rd = 8'h00;
      o_spi_cs_n = 1'b0;
      repeat (3) @(negedge i_core_clk);
      for (k = 0; k < 16; k++) begin
         idx = lsb_first ? (k < 8 ? k + 8 : k - 8) : 15 - k;
         // Line released in a read's data phase, so it toggles
         o_mosi = (k > 7 && ins[7]) ? ~o_mosi : sh[idx];
         repeat (4) @(negedge i_core_clk);
         o_spi_clk = 1'b1;
         // Sampled late in the high phase: the device sees edges through a synchroniser
         repeat (3) @(negedge i_core_clk);
         if (k > 7) rd[idx] = i_miso;
         repeat (1) @(negedge i_core_clk);
         o_spi_clk = 1'b0;
      end
      repeat (4) @(negedge i_core_clk);
      o_spi_cs_n = 1'b1;
      repeat (4) @(negedge i_core_clk);
   endtask
endmodule // dmc_spi_host

/* File: tb_dmc_mode_regs.sv */
/*
 Self-checking bench: register walk, modes, pin inversions, bit order, soft reset.
 Assumes the serial host model dmc_spi_host.
*/
`timescale 1ns/100ps
module tb_dmc_mode_regs;
   import dmc_pkg::*;
   localparam logic [7:0] VER = 8'h5c; // Arbitrary value
   typedef struct packed {logic [4:0] adr; logic [7:0] wd; logic [7:0] rd;} dmc_row_type;
   // Last two rows hit the read-only and an unmapped address
   localparam dmc_row_type ROWS [0:14] = '{
      '{5'h00, 8'h1f, 8'h1c}, '{5'h01, 8'hff, 8'hff}, '{5'h02, 8'hff, 8'hf7},
      '{5'h03, 8'hff, 8'h83}, '{5'h04, 8'h7f, 8'h47}, '{5'h05, 8'ha5, 8'ha5},
      '{5'h06, 8'hff, 8'h0f}, '{5'h07, 8'h96, 8'h96}, '{5'h08, 8'hff, 8'h83},
      '{5'h09, 8'h3c, 8'h3c}, '{5'h0a, 8'hf3, 8'h03}, '{5'h0b, 8'h69, 8'h69},
      '{5'h0c, 8'h7d, 8'h01}, '{5'h0d, 8'hff, VER}, '{5'h1f, 8'hff, 8'h00}};
   logic i_core_clk, i_rst, i_loop_locked, i_single_port_clock_raw, i_channel_select;
   logic spi_clk, spi_cs_n, mosi, miso, sdio_line;
   logic tgl = 1'b0;
   logic o_sdio, o_sdio_oe_n, o_sdo, o_sdo_oe_n, o_single_port_clock, o_channel_select_eff;
   logic o_restart, o_sdio_bidir, o_lsb_first, o_single_resistor, o_real_mix, o_pin8_is_clock;
   logic o_data_clk_invert, o_q_first, o_loop_enable, o_i_offset_to_comp, o_q_offset_to_comp;
   logic o_sleep, o_power_down, o_zero_stuff, o_mod_positive, o_unsigned_data, o_one_port;
   logic o_clk_strong, o_clk_on_sdo, o_pump_manual;
   logic [1:0] o_interp_sel, o_mod_sel, o_prescale_sel;
   logic [2:0] o_pump_current;
   logic [3:0] o_i_coarse_gain, o_q_coarse_gain;
   logic [7:0] o_i_fine_gain, o_q_fine_gain, rd;
   logic [9:0] o_i_offset_mag, o_q_offset_mag;
   logic [7:0] restarts = 8'h00;
   int mismatches = 0;
   int cmp_count = 0;
   int k;
   wire [22:0] i_set = {o_i_fine_gain, o_i_coarse_gain, o_i_offset_mag, o_i_offset_to_comp};
   wire [22:0] q_set = {o_q_fine_gain, o_q_coarse_gain, o_q_offset_mag, o_q_offset_to_comp};
   wire [10:0] dflt = {o_sdio_bidir, o_lsb_first, o_mod_sel, o_pin8_is_clock, o_loop_enable,
      o_q_first, o_data_clk_invert, o_real_mix, o_sdio_oe_n, o_sdo_oe_n};
   wire [13:0] misc = {o_sleep, o_power_down, o_zero_stuff, o_mod_positive, o_unsigned_data,
      o_one_port, o_clk_strong, o_clk_on_sdo, o_prescale_sel, o_pump_manual, o_pump_current};
   // Whoever holds the enable drives the shared pin; a released line toggles
   assign sdio_line = o_sdio_oe_n ? mosi : o_sdio;
   assign miso = !o_sdio_oe_n ? o_sdio : (!o_sdo_oe_n ? o_sdo : tgl);
   initial begin
      i_core_clk = 1'b0;
      forever #50 i_core_clk = ~i_core_clk;
   end
   always @(negedge i_core_clk) tgl <= ~tgl;
   always @(posedge i_core_clk) if (o_restart === 1'b1) restarts <= restarts + 8'h01;
   dmc_spi_host host (.i_core_clk, .i_miso(miso), .o_spi_clk(spi_clk), .o_spi_cs_n(spi_cs_n),
      .o_mosi(mosi));
   dmc_mode_regs #(.VERSION_ID(VER)) uut (.i_core_clk, .i_rst, .i_spi_clk(spi_clk),
      .i_spi_cs_n(spi_cs_n), .i_sdio(sdio_line), .o_sdio, .o_sdio_oe_n, .o_sdo, .o_sdo_oe_n,
      .i_loop_locked, .i_single_port_clock_raw, .i_channel_select, .o_single_port_clock,
      .o_channel_select_eff, .o_restart, .o_sdio_bidir, .o_lsb_first, .o_sleep,
      .o_power_down, .o_single_resistor, .o_interp_sel, .o_mod_sel, .o_zero_stuff,
      .o_real_mix, .o_mod_positive, .o_pin8_is_clock, .o_unsigned_data, .o_one_port,
      .o_clk_strong, .o_data_clk_invert, .o_q_first, .o_clk_on_sdo, .o_prescale_sel,
      .o_loop_enable, .o_pump_manual, .o_pump_current, .o_i_fine_gain, .o_i_coarse_gain,
      .o_i_offset_mag, .o_i_offset_to_comp, .o_q_fine_gain, .o_q_coarse_gain, .o_q_offset_mag,
      .o_q_offset_to_comp);
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      host.xfer({3'b000, a}, d, rd);
   endtask
   task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
      host.xfer({3'b100, a}, 8'h00, rd);
      chk(rd, e);
   endtask
   task automatic endt(input string s);
      $display("Test %s finished", s);
   endtask
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #3000000;
      mismatches++;
      $display("Error at %0t: run limit reached", $time);
      test_done;
   end
   initial begin
      i_rst = 1'b1;
      i_loop_locked = 1'b1;
      i_single_port_clock_raw = 1'b0;
      i_channel_select = 1'b0;
      repeat (5) @(negedge i_core_clk);
      i_rst = 1'b0;
      repeat (3) @(negedge i_core_clk);
      chk(dflt, 11'h007);
      endt("defaults");
      for (k = 0; k < 15; k++) begin
         wr(ROWS[k].adr, ROWS[k].wd);
         rdchk(ROWS[k].adr, ROWS[k].rd);
      end
      chk(i_set, {8'ha5, 4'hf, 8'h96, 2'h3, 1'b1});
      chk(q_set, {8'h3c, 4'h3, 8'h69, 2'h1, 1'b0});
      chk(o_single_resistor, 1'b1);
      chk(misc, 14'h3fff);
      chk(dflt, 11'h1df);
      chk({o_single_port_clock, o_channel_select_eff}, 2'b11);
      i_single_port_clock_raw = 1'b1;
      i_channel_select = 1'b1;
      repeat (6) @(negedge i_core_clk);
      chk({o_single_port_clock, o_channel_select_eff}, 2'b00);
      endt("register walk");
      for (k = 0; k < 4; k++) begin
         wr(DMC_A_FILTER, {k[1:0], ~k[1:0], 4'h4});
         chk({o_interp_sel, o_mod_sel}, {k[1:0], ~k[1:0]});
      end
      endt("modes");
      wr(DMC_A_LOOP, 8'h80);
      wr(DMC_A_SERIAL, 8'hc4);
      host.lsb_first = 1'b1;
      rdchk(DMC_A_SERIAL, 8'hc6);
      // Lock bit must follow the pin, not stick high
      i_loop_locked = 1'b0;
      rdchk(DMC_A_SERIAL, 8'hc4);
      chk(restarts, 8'h00);
      wr(DMC_A_SERIAL, 8'h24);
      host.lsb_first = 1'b0;
      chk({restarts, o_single_port_clock, o_channel_select_eff}, {8'h01, 2'b11});
      chk(misc, 14'h0000);
      rdchk(DMC_A_SERIAL, 8'h04);
      rdchk(DMC_A_FILTER, 8'h04);
      rdchk(DMC_A_I_OFS_HI, 8'h00);
      endt("bit order and soft reset");
      test_done;
   end
endmodule // tb_dmc_mode_regs
